// *** hw/bsw_cmd_class.sv ***
`timescale 1ns/1ps
module bsw_cmd_class
	import bsw_pkg::*;
#(
	parameter logic [63:0] DEF_MASK  = 64'h0000_000F_1FFF_FFFF,
	parameter logic [63:0] IMPL_MASK = 64'h0000_000F_1FFF_FFFF,
	parameter logic [63:0] WR_MASK   = 64'h0000_0000_0000_001F
) (
	input  wire logic [7:0] code,
	input  wire logic       is_write,
	input  wire logic       size_ok,
	input  wire logic       busy,
	input  wire logic       overflow,
	input  wire logic       fault,
	output bsw_err_t        err
);

	if ((IMPL_MASK & ~DEF_MASK) != 64'h0) begin : g_chk
		$error("implemented codes must be a subset of defined codes");
	end

	logic in_map;
	assign in_map = (code[7:6] == 2'h0);

	// ----------------------------------------------------------------
	// outcome priority
	// ----------------------------------------------------------------
	always_comb begin
		if (busy) begin
			err = BSW_ERR_BUSY;
		end else if (!in_map || !DEF_MASK[code[5:0]]) begin
			err = BSW_ERR_RSVD;
		end else if (!IMPL_MASK[code[5:0]]) begin
			err = BSW_ERR_UNSUP;
		end else if (is_write && !WR_MASK[code[5:0]]) begin
			err = BSW_ERR_DENIED;
		end else if (is_write && !size_ok) begin
			err = BSW_ERR_SIZE;
		end else if (overflow) begin
			err = BSW_ERR_OVF;
		end else if (fault) begin
			err = BSW_ERR_UNKNOWN;
		end else begin
			err = BSW_ERR_OK;
		end
	end

endmodule

// *** hw/bsw_pkg.sv ***
package bsw_pkg;

	// ----------------------------------------------------------------
	// command codes
	// ----------------------------------------------------------------
	localparam logic [7:0]  BSW_CMD_STATUS   = 8'h16;

	// ----------------------------------------------------------------
	// flag positions in the status word
	// ----------------------------------------------------------------
	localparam int          BSW_BIT_OVC      = 15;
	localparam int          BSW_BIT_TCA      = 14;
	localparam int          BSW_BIT_RSV_HI   = 13;
	localparam int          BSW_BIT_OTA      = 12;
	localparam int          BSW_BIT_TDA      = 11;
	localparam int          BSW_BIT_RSV_LO   = 10;
	localparam int          BSW_BIT_RCA      = 9;
	localparam int          BSW_BIT_RTA      = 8;
	localparam int          BSW_BIT_INIT     = 7;
	localparam int          BSW_BIT_DSG      = 6;
	localparam int          BSW_BIT_FC       = 5;
	localparam int          BSW_BIT_FD       = 4;
	localparam int          BSW_ERR_LSB      = 0;
	localparam int          BSW_ERR_W        = 3;

	// ----------------------------------------------------------------
	// error codes, in numeric order 0 to 7
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		BSW_ERR_OK,
		BSW_ERR_BUSY,
		BSW_ERR_RSVD,
		BSW_ERR_UNSUP,
		BSW_ERR_DENIED,
		BSW_ERR_OVF,
		BSW_ERR_SIZE,
		BSW_ERR_UNKNOWN
	} bsw_err_t;

	// ----------------------------------------------------------------
	// reset values and fixed figures
	// ----------------------------------------------------------------
	localparam logic        BSW_RST_FLAG     = 1'h0;
	localparam logic        BSW_RST_DSG      = 1'h1;
	localparam logic [2:0]  BSW_ALARM_ERR    = 3'h7;
	localparam logic [7:0]  BSW_FD_CLR_PCT   = 8'h14;
	localparam logic [15:0] BSW_CV_CC        = 16'hFFFF;
	localparam logic [1:0]  BSW_OVC_CLR_MAH  = 2'h2;

endpackage

// *** hw/bsw_status.sv ***
// Functional notes
// - host reads status word with read-word command 0x16; device returns it unless busy.
// - alarm bits at 15,14,12,11,9,8; bits 13 and 10 reserved zero.
// - status bits initialized 7, discharging 6, fully charged 5, discharged 4.
// - low three bits hold outcome code of the last command other than a non-busy status read, 0 to 7.
// - alarm broadcast sends the same flags with error bits all ones.
// - capacity and time alarms use current or power quantities by mode bit.
// - overcharge set past full plus margin; cleared after 2 mAh idle/discharge.
// - charge-terminate set on primary termination, cleared when charging stops.
// - over-temperature set at limit for direction, cleared below reset threshold.
// - discharge-terminate set on empty, low voltage, cold or undervoltage.
// - low-capacity set below threshold; cleared by threshold change or charging.
// - low-time set below threshold; cleared by threshold change or charging.
// - initialized set on good config load, cleared on bad load.
// - discharging flag set whenever not charging, cleared when charging.
// - fully charged set on termination or overcharge, cleared below clear percent.
// - fully discharged set on low voltage or low percent; cleared at 20%.
// - write to read-only gives access denied; wrong block length gives bad size.
// - reserved codes give reserved; undone defined give unsupported; busy when busy.
// - charge voltage in mV; 65535 asks for constant-current operation.
// - mode bit clear selects mAh quantities, set selects 10 mWh quantities.
`timescale 1ns/1ps
module bsw_status
	import bsw_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic        cmd_valid,
	input  wire logic [7:0]  cmd_code,
	input  wire logic        cmd_write,
	input  wire logic        cmd_size_ok,
	input  wire logic        cmd_busy,
	input  wire logic        cmd_overflow,
	input  wire logic        cmd_fault,
	input  wire logic        capacity_mode,
	input  wire logic        charging,
	input  wire logic        idle_mah_tick,
	input  wire logic        primary_term,
	input  wire logic        flash_load_ok,
	input  wire logic        flash_load_bad,
	input  wire logic [15:0] remaining_charge_mah,
	input  wire logic [15:0] remaining_charge_mwh,
	input  wire logic [15:0] full_charge_mah,
	input  wire logic [15:0] full_charge_mwh,
	input  wire logic [15:0] overcharge_margin,
	input  wire logic [15:0] capacity_threshold,
	input  wire logic [15:0] runtime_threshold,
	input  wire logic [15:0] est_runtime_i,
	input  wire logic [15:0] est_runtime_p,
	input  wire logic [15:0] averaged_runtime_i,
	input  wire logic [15:0] averaged_runtime_p,
	input  wire logic [15:0] temperature,
	input  wire logic [15:0] ot_chg_limit,
	input  wire logic [15:0] ot_chg_reset,
	input  wire logic [15:0] ot_dsg_limit,
	input  wire logic [15:0] ot_dsg_reset,
	input  wire logic [15:0] suspend_temp_low,
	input  wire logic [15:0] pack_voltage,
	input  wire logic [15:0] cell_voltage,
	input  wire logic [15:0] terminate_voltage,
	input  wire logic [15:0] second_end_of_discharge_level,
	input  wire logic        cell_undervoltage_flag,
	input  wire logic [15:0] current_mag,
	input  wire logic [15:0] overload_current,
	input  wire logic [7:0]  relative_charge_percent,
	input  wire logic [7:0]  full_clear_percent,
	input  wire logic [7:0]  battery_low_percent,
	input  wire logic [15:0] requested_charge_voltage,
	output logic             rd_valid_q,
	output logic [15:0]      rd_word_q,
	output logic             alarm_send_q,
	output logic [15:0]      alarm_broadcast_q,
	output logic [15:0]      battery_flag_word_q,
	output logic [15:0]      charge_voltage_q,
	output logic             const_current_q
);

	// ----------------------------------------------------------------
	// unit selection
	// ----------------------------------------------------------------
	logic [15:0] rem_sel;
	logic [15:0] full_sel;
	logic [15:0] est_sel;
	logic [15:0] avg_sel;
	logic [16:0] ovc_limit;
	assign rem_sel   = capacity_mode ? remaining_charge_mwh : remaining_charge_mah;
	assign full_sel  = capacity_mode ? full_charge_mwh : full_charge_mah;
	assign est_sel   = capacity_mode ? est_runtime_p : est_runtime_i;
	assign avg_sel   = capacity_mode ? averaged_runtime_p : averaged_runtime_i;
	assign ovc_limit = {1'b0, full_sel} + {1'b0, overcharge_margin};

	// ----------------------------------------------------------------
	// flag registers
	// ----------------------------------------------------------------
	logic       ovc_q;
	logic       tca_q;
	logic       ota_q;
	logic       tda_q;
	logic       rca_q;
	logic       rta_q;
	logic       init_q;
	logic       dsg_q;
	logic       fc_q;
	logic       fd_q;
	logic [1:0] ovc_cnt_q;
	logic [15:0] rem_prev_q;
	logic [15:0] avg_prev_q;
	bsw_err_t   err_q;
	logic ovc_set;
	logic ovc_clr;
	logic ota_set;
	logic ota_clr;
	logic tda_set;
	logic tda_clr;
	logic rca_clr;
	logic rta_clr;
	logic fd_set;
	assign ovc_set = charging && ({1'b0, rem_sel} > ovc_limit);
	assign ovc_clr = !charging && (ovc_cnt_q >= BSW_OVC_CLR_MAH);
	always_ff @(posedge clk) begin
		if (srst || charging) begin
			ovc_cnt_q <= 2'h0;
		end else if (idle_mah_tick && ovc_cnt_q < BSW_OVC_CLR_MAH) begin
			ovc_cnt_q <= ovc_cnt_q + 2'h1;
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			ovc_q <= BSW_RST_FLAG;
		end else if (ovc_set) begin
			ovc_q <= 1'b1;
		end else if (ovc_clr) begin
			ovc_q <= 1'b0;
		end
	end
	// set wins over clear
	always_ff @(posedge clk) begin
		if (srst) begin
			tca_q <= BSW_RST_FLAG;
		end else begin
			tca_q <= primary_term || (tca_q && charging);
		end
	end
	assign ota_set = charging ? (temperature >= ot_chg_limit)
	                          : (temperature >= ot_dsg_limit);
	assign ota_clr = charging ? (temperature < ot_chg_reset)
	                          : (temperature < ot_dsg_reset);
	always_ff @(posedge clk) begin
		if (srst) begin
			ota_q <= BSW_RST_FLAG;
		end else begin
			ota_q <= ota_set || (ota_q && !ota_clr);
		end
	end
	assign tda_set = (rem_sel == 16'h0000) || (pack_voltage <= terminate_voltage)
	              || (temperature <= suspend_temp_low) || cell_undervoltage_flag;
	assign tda_clr = (pack_voltage > terminate_voltage) && (rem_sel != 16'h0000)
	              && !cell_undervoltage_flag;
	always_ff @(posedge clk) begin
		if (srst) begin
			tda_q <= BSW_RST_FLAG;
		end else begin
			tda_q <= tda_set || (tda_q && !tda_clr);
		end
	end
	// previous values detect a rise caused by charging
	always_ff @(posedge clk) begin
		if (srst) begin
			rem_prev_q <= 16'h0000;
			avg_prev_q <= 16'h0000;
		end else begin
			rem_prev_q <= rem_sel;
			avg_prev_q <= avg_sel;
		end
	end
	assign rca_clr = (capacity_threshold < rem_sel) || (charging && rem_sel > rem_prev_q);
	assign rta_clr = (runtime_threshold < avg_sel) || (charging && avg_sel > avg_prev_q);
	always_ff @(posedge clk) begin
		if (srst) begin
			rca_q <= BSW_RST_FLAG;
		end else if (rem_sel < capacity_threshold) begin
			rca_q <= 1'b1;
		end else if (rca_clr) begin
			rca_q <= 1'b0;
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			rta_q <= BSW_RST_FLAG;
		end else if (est_sel < runtime_threshold) begin
			rta_q <= 1'b1;
		end else if (rta_clr) begin
			rta_q <= 1'b0;
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			init_q <= BSW_RST_FLAG;
		end else begin
			init_q <= flash_load_ok || (init_q && !flash_load_bad);
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			dsg_q <= BSW_RST_DSG;
		end else begin
			dsg_q <= !charging;
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			fc_q <= BSW_RST_FLAG;
		end else if (primary_term || ovc_set) begin
			fc_q <= 1'b1;
		end else if (relative_charge_percent < full_clear_percent) begin
			fc_q <= 1'b0;
		end
	end
	assign fd_set = (((pack_voltage < second_end_of_discharge_level)
	              || (cell_voltage < second_end_of_discharge_level))
	              && (current_mag < overload_current))
	              || (relative_charge_percent < battery_low_percent);
	always_ff @(posedge clk) begin
		if (srst) begin
			fd_q <= BSW_RST_FLAG;
		end else if (fd_set) begin
			fd_q <= 1'b1;
		end else if (relative_charge_percent >= BSW_FD_CLR_PCT) begin
			fd_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// last command outcome
	// ----------------------------------------------------------------
	bsw_err_t cls_err;
	logic     status_rd;
	assign status_rd = cmd_valid && !cmd_write && (cmd_code == BSW_CMD_STATUS);
	bsw_cmd_class u_class (
		.code     (cmd_code),
		.is_write (cmd_write),
		.size_ok  (cmd_size_ok),
		.busy     (cmd_busy),
		.overflow (cmd_overflow),
		.fault    (cmd_fault),
		.err      (cls_err)
	);
	always_ff @(posedge clk) begin
		if (srst) begin
			err_q <= BSW_ERR_OK;
		end else if (cmd_valid && !(status_rd && !cmd_busy)) begin
			err_q <= cls_err;
		end
	end

	// ----------------------------------------------------------------
	// word assembly and read answer
	// ----------------------------------------------------------------
	logic [15:0] status_w;
	always_comb begin
		status_w                   = 16'h0000;
		status_w[BSW_BIT_OVC]      = ovc_q;
		status_w[BSW_BIT_TCA]      = tca_q;
		status_w[BSW_BIT_OTA]      = ota_q;
		status_w[BSW_BIT_TDA]      = tda_q;
		status_w[BSW_BIT_RCA]      = rca_q;
		status_w[BSW_BIT_RTA]      = rta_q;
		status_w[BSW_BIT_INIT]     = init_q;
		status_w[BSW_BIT_DSG]      = dsg_q;
		status_w[BSW_BIT_FC]       = fc_q;
		status_w[BSW_BIT_FD]       = fd_q;
		status_w[BSW_ERR_LSB +: BSW_ERR_W] = err_q;
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			battery_flag_word_q <= 16'h0000;
		end else begin
			battery_flag_word_q <= status_w;
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			rd_valid_q <= 1'b0;
			rd_word_q  <= 16'h0000;
		end else begin
			rd_valid_q <= status_rd && !cmd_busy;
			if (status_rd && !cmd_busy) begin
				rd_word_q <= status_w;
			end
		end
	end

	// ----------------------------------------------------------------
	// alarm broadcast on a newly raised alarm
	// ----------------------------------------------------------------
	logic [7:0] alarm_prev_q;
	logic       alarm_rise;
	assign alarm_rise = |(status_w[15:8] & ~alarm_prev_q);
	always_ff @(posedge clk) begin
		if (srst) begin
			alarm_prev_q      <= 8'h00;
			alarm_send_q      <= 1'b0;
			alarm_broadcast_q <= 16'h0000;
		end else begin
			alarm_prev_q <= status_w[15:8];
			alarm_send_q <= alarm_rise;
			if (alarm_rise) begin
				alarm_broadcast_q <= {status_w[15:BSW_ERR_W], BSW_ALARM_ERR};
			end
		end
	end

	// ----------------------------------------------------------------
	// charge voltage request
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			charge_voltage_q <= 16'h0000;
			const_current_q  <= 1'b0;
		end else begin
			charge_voltage_q <= requested_charge_voltage;
			const_current_q  <= (requested_charge_voltage == BSW_CV_CC);
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_status_read: assert property (@(posedge clk) disable iff (srst)
		status_rd && !cmd_busy |=> rd_valid_q && rd_word_q == $past(status_w))
		else $error("status read not answered with the word");
	a_reserved_zero: assert property (@(posedge clk) disable iff (srst)
		rd_valid_q |-> !rd_word_q[BSW_BIT_RSV_HI] && !rd_word_q[BSW_BIT_RSV_LO])
		else $error("reserved bit set in answer");
	a_alarm_ones: assert property (@(posedge clk) disable iff (srst)
		alarm_rise |=> alarm_send_q && alarm_broadcast_q[2:0] == BSW_ALARM_ERR
			&& alarm_broadcast_q[15:3] == $past(status_w[15:3]))
		else $error("broadcast word wrong");
	a_ovc_clear: assert property (@(posedge clk) disable iff (srst)
		$fell(ovc_q) |-> $past(!charging) && $past(ovc_cnt_q) == BSW_OVC_CLR_MAH)
		else $error("overcharge cleared early");
	a_term_flags: assert property (@(posedge clk) disable iff (srst)
		primary_term |=> tca_q && fc_q)
		else $error("termination did not set flags");
	a_tda_hold: assert property (@(posedge clk) disable iff (srst)
		tda_q && cell_undervoltage_flag |=> tda_q)
		else $error("discharge-terminate cleared under undervoltage");
	a_dsg_track: assert property (@(posedge clk) disable iff (srst)
		charging ##1 charging |-> !dsg_q)
		else $error("discharging flag set while charging");
	a_fd_clear: assert property (@(posedge clk) disable iff (srst)
		relative_charge_percent >= BSW_FD_CLR_PCT && !fd_set |=> !fd_q)
		else $error("fully discharged not cleared");
	a_denied: assert property (@(posedge clk) disable iff (srst)
		cmd_valid && cmd_write && cmd_code == BSW_CMD_STATUS && !cmd_busy
			|=> err_q == BSW_ERR_DENIED)
		else $error("write to status not denied");
	a_read_keeps: assert property (@(posedge clk) disable iff (srst)
		status_rd && !cmd_busy |=> err_q == $past(err_q))
		else $error("status read altered error code");
	a_cc_mode: assert property (@(posedge clk) disable iff (srst)
		requested_charge_voltage == BSW_CV_CC |=> const_current_q)
		else $error("constant-current request missed");
endmodule

// *** verif/bsw_host_model.sv ***
`timescale 1ns/1ps
module bsw_host_model
	import bsw_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic       start,
	input  wire logic [7:0] code,
	input  wire logic [4:0] qual,
	input  wire logic       const_current_q,
	output logic            cmd_valid,
	output logic [7:0]      cmd_code,
	output logic            cmd_write,
	output logic            cmd_size_ok,
	output logic            cmd_busy,
	output logic            cmd_overflow,
	output logic            cmd_fault,
	output logic            cc_source
);
	// ----------------------------------------------------------------
	// command issue
	// ----------------------------------------------------------------
	// one-cycle command; idle qualifiers toggle so stale values never look valid
	always_ff @(posedge clk) begin
		if (srst) begin
			{cmd_valid, cmd_code} <= 9'h000;
			{cmd_write, cmd_size_ok, cmd_busy, cmd_overflow, cmd_fault} <= 5'h00;
		end else begin
			cmd_valid <= start;
			cmd_code <= start ? code : ~cmd_code;
			{cmd_write, cmd_size_ok, cmd_busy, cmd_overflow, cmd_fault} <= start ? qual :
				~{cmd_write, cmd_size_ok, cmd_busy, cmd_overflow, cmd_fault};
		end
	end

	// ----------------------------------------------------------------
	// charger side
	// ----------------------------------------------------------------
	always_comb cc_source = const_current_q;
endmodule

// *** verif/testbench.sv ***
`timescale 1ns/1ps
`define CMP(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module testbench
	import bsw_pkg::*;
;
	logic        clk, srst, start, capacity_mode, charging, idle_mah_tick, primary_term;
	logic        flash_load_ok, flash_load_bad, cell_undervoltage_flag, cc_source;
	logic [15:0] remaining_charge_mah, remaining_charge_mwh, full_charge_mah, full_charge_mwh;
	logic [15:0] overcharge_margin, capacity_threshold, runtime_threshold, est_runtime_i;
	logic [15:0] est_runtime_p, averaged_runtime_i, averaged_runtime_p, temperature;
	logic [15:0] ot_chg_limit, ot_chg_reset, ot_dsg_limit, ot_dsg_reset, suspend_temp_low;
	logic [15:0] pack_voltage, cell_voltage, terminate_voltage, second_end_of_discharge_level;
	logic [15:0] current_mag, overload_current, requested_charge_voltage, v, ef, exp_w;
	logic [7:0]  relative_charge_percent, full_clear_percent, battery_low_percent, code, alarms;
	logic [4:0]  qual;
	logic        cmd_valid, cmd_write, cmd_size_ok, cmd_busy, cmd_overflow, cmd_fault;
	logic [7:0]  cmd_code;
	logic        rd_valid_q, alarm_send_q, const_current_q;
	logic [15:0] rd_word_q, alarm_broadcast_q, battery_flag_word_q, charge_voltage_q;
	bsw_err_t    exp_err;
	logic [15:0] exp_q[$];
	int          miscompares = 0;
	int          comparisons = 0;
	integer      seed = 32'h3219;

	bsw_status u_dut (.clk, .srst, .cmd_valid, .cmd_code, .cmd_write, .cmd_size_ok, .cmd_busy,
		.cmd_overflow, .cmd_fault, .capacity_mode, .charging, .idle_mah_tick, .primary_term,
		.flash_load_ok, .flash_load_bad, .remaining_charge_mah, .remaining_charge_mwh,
		.full_charge_mah, .full_charge_mwh, .overcharge_margin, .capacity_threshold,
		.runtime_threshold, .est_runtime_i, .est_runtime_p, .averaged_runtime_i,
		.averaged_runtime_p, .temperature, .ot_chg_limit, .ot_chg_reset, .ot_dsg_limit,
		.ot_dsg_reset, .suspend_temp_low, .pack_voltage, .cell_voltage, .terminate_voltage,
		.second_end_of_discharge_level, .cell_undervoltage_flag, .current_mag,
		.overload_current, .relative_charge_percent, .full_clear_percent,
		.battery_low_percent, .requested_charge_voltage, .rd_valid_q, .rd_word_q,
		.alarm_send_q, .alarm_broadcast_q, .battery_flag_word_q, .charge_voltage_q,
		.const_current_q);

	bsw_host_model u_host (.clk, .srst, .start, .code, .qual, .const_current_q, .cmd_valid,
		.cmd_code, .cmd_write, .cmd_size_ok, .cmd_busy, .cmd_overflow, .cmd_fault, .cc_source);

	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic complete_run();
		$display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// qual is {write, size_ok, busy, overflow, fault}
	task automatic send(input logic [7:0] c, input logic [4:0] q);
		code = c;
		qual = q;
		start = 1'h1;
		@(posedge clk);
		#1 start = 1'h0;
		repeat (2) @(posedge clk);
		#1;
	endtask

	// let flags settle, note the expected word, then read it
	task automatic chk();
		repeat (3) @(posedge clk);
		#1 exp_q.push_back({ef[15:3], exp_err});
		`CMP(battery_flag_word_q, {ef[15:3], exp_err})
		send(BSW_CMD_STATUS, 5'h08);
	endtask

	task automatic err_case(input logic [7:0] c, input logic [4:0] q, input bsw_err_t e);
		send(c, q);
		exp_err = e;
		chk();
	endtask

	task automatic tick();
		idle_mah_tick = 1'h1;
		@(posedge clk);
		#1 idle_mah_tick = 1'h0;
	endtask

	task automatic done(input string s);
		$display("test %0s done", s);
	endtask

	// ----------------------------------------------------------------
	// result watchers
	// ----------------------------------------------------------------
	always @(negedge clk) begin
		if (rd_valid_q === 1'h1) begin
			exp_w = (exp_q.size() != 0) ? exp_q.pop_front() : 16'hXXXX;
			`CMP(rd_word_q, exp_w)
		end
		if (alarm_send_q === 1'h1) begin
			alarms++;
			`CMP(alarm_broadcast_q, {ef[15:3], 3'h7})
		end
	end

	initial begin
		#200000;
		miscompares++;
		complete_run();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{srst, start, code, qual, alarms} = {1'h1, 1'h0, 8'h00, 5'h00, 8'h00};
		{capacity_mode, charging, idle_mah_tick, primary_term} = 4'h0;
		{flash_load_ok, flash_load_bad, cell_undervoltage_flag} = 3'h0;
		{remaining_charge_mah, remaining_charge_mwh} = {16'h03E8, 16'h03E8};
		{full_charge_mah, full_charge_mwh, overcharge_margin} = {16'h07D0, 16'h07D0, 16'h0064};
		{capacity_threshold, runtime_threshold} = {16'h0064, 16'h000A};
		{est_runtime_i, est_runtime_p} = {16'h01F4, 16'h01F4};
		{averaged_runtime_i, averaged_runtime_p} = {16'h01F4, 16'h01F4};
		{temperature, ot_chg_limit, ot_chg_reset} = {16'h012C, 16'h01C2, 16'h0190};
		{ot_dsg_limit, ot_dsg_reset, suspend_temp_low} = {16'h01F4, 16'h01C2, 16'h0064};
		{pack_voltage, cell_voltage, terminate_voltage} = {16'h2EE0, 16'h0FA0, 16'h2328};
		{second_end_of_discharge_level, current_mag} = {16'h0BB8, 16'h0064};
		{overload_current, requested_charge_voltage} = {16'h1388, 16'h3070};
		{relative_charge_percent, full_clear_percent, battery_low_percent} = 24'h325F05;
		ef = 16'h0040;
		exp_err = BSW_ERR_OK;
		repeat (2) @(posedge clk);
		#1 srst = 1'h0;
		chk();
		flash_load_ok = 1'h1;
		@(posedge clk);
		#1 flash_load_ok = 1'h0;
		ef[BSW_BIT_INIT] = 1'h1;
		chk();
		flash_load_bad = 1'h1;
		@(posedge clk);
		#1 flash_load_bad = 1'h0;
		ef[BSW_BIT_INIT] = 1'h0;
		chk();
		done("reset_and_init");

		err_case(8'h16, 5'h0C, BSW_ERR_BUSY);
		err_case(8'($random(seed)) | 8'h40, 5'h08, BSW_ERR_RSVD);
		err_case(8'h1D, 5'h08, BSW_ERR_RSVD);
		err_case(8'h16, 5'h18, BSW_ERR_DENIED);
		err_case(8'h01, 5'h10, BSW_ERR_SIZE);
		err_case(8'h0D, 5'h0A, BSW_ERR_OVF);
		err_case(8'h0D, 5'h09, BSW_ERR_UNKNOWN);
		chk();
		err_case(8'h0D, 5'h08, BSW_ERR_OK);
		done("error_codes");

		relative_charge_percent = 8'h64;
		charging = 1'h1;
		ef[BSW_BIT_DSG] = 1'h0;
		chk();
		primary_term = 1'h1;
		@(posedge clk);
		#1 primary_term = 1'h0;
		{ef[BSW_BIT_TCA], ef[BSW_BIT_FC]} = 2'h3;
		chk();
		remaining_charge_mah = 16'h0835;
		ef[BSW_BIT_OVC] = 1'h1;
		chk();
		remaining_charge_mah = 16'h03E8;
		charging = 1'h0;
		{ef[BSW_BIT_TCA], ef[BSW_BIT_DSG]} = 2'h1;
		chk();
		tick();
		chk();
		tick();
		ef[BSW_BIT_OVC] = 1'h0;
		chk();
		relative_charge_percent = 8'h5A;
		ef[BSW_BIT_FC] = 1'h0;
		chk();
		done("charge_cycle");

		temperature = 16'h01F4;
		ef[BSW_BIT_OTA] = 1'h1;
		chk();
		temperature = 16'h01C2;
		chk();
		temperature = 16'h01C1;
		ef[BSW_BIT_OTA] = 1'h0;
		chk();
		pack_voltage = 16'h2328;
		ef[BSW_BIT_TDA] = 1'h1;
		chk();
		pack_voltage = 16'h2329;
		ef[BSW_BIT_TDA] = 1'h0;
		chk();
		cell_undervoltage_flag = 1'h1;
		ef[BSW_BIT_TDA] = 1'h1;
		chk();
		cell_undervoltage_flag = 1'h0;
		ef[BSW_BIT_TDA] = 1'h0;
		chk();
		done("temperature_and_terminate");

		capacity_mode = 1'h1;
		remaining_charge_mah = 16'h0032;
		est_runtime_i = 16'h0005;
		chk();
		capacity_mode = 1'h0;
		est_runtime_i = 16'h01F4;
		ef[BSW_BIT_RCA] = 1'h1;
		chk();
		remaining_charge_mah = 16'h03E8;
		ef[BSW_BIT_RCA] = 1'h0;
		chk();
		est_runtime_i = 16'h0005;
		ef[BSW_BIT_RTA] = 1'h1;
		chk();
		est_runtime_i = 16'h01F4;
		ef[BSW_BIT_RTA] = 1'h0;
		chk();
		relative_charge_percent = 8'h04;
		ef[BSW_BIT_FD] = 1'h1;
		chk();
		relative_charge_percent = 8'h13;
		chk();
		relative_charge_percent = 8'h14;
		ef[BSW_BIT_FD] = 1'h0;
		chk();
		done("capacity_time_discharge");

		requested_charge_voltage = 16'hFFFF;
		repeat (2) @(posedge clk);
		#1 `CMP({const_current_q, cc_source}, 2'h3)
		v = 16'($random(seed)) & 16'h7FFF;
		requested_charge_voltage = v;
		repeat (2) @(posedge clk);
		#1 `CMP({const_current_q, charge_voltage_q}, {1'h0, v})
		`CMP(alarms, 8'h07)
		`CMP(exp_q.size(), 0)
		done("charge_voltage");
		complete_run();
	end
endmodule
